// file: hdl/dsps_defines.svh
// Constants for the dual-slope phase sequencer: clock, count period, phase codes.
// Assumes a 125 MHz system clock and a 1 us conversion count period by default.
`ifndef DSPS_DEFINES_SVH
`define DSPS_DEFINES_SVH

// ==========================================================
// Clock and count period
`define DSPS_CLK_MHZ 125
`define DSPS_COUNT_NS 1000
`define DSPS_TICK_CYCLES ((`DSPS_COUNT_NS * `DSPS_CLK_MHZ) / 1000)

// ==========================================================
// Integration length as whole mains periods
`define DSPS_LINE_PERIOD_US 16500
`define DSPS_LINE_COUNTS ((`DSPS_LINE_PERIOD_US * 1000) / `DSPS_COUNT_NS)
`define DSPS_INT_LINES 4
`define DSPS_DEINT_FACTOR 2

// ==========================================================
// Comparator lag, rounded up to whole counts
`define DSPS_CMP_LAG_NS 2000
`define DSPS_CMP_LAG_COUNTS ((`DSPS_CMP_LAG_NS + `DSPS_COUNT_NS - 1) / `DSPS_COUNT_NS)

// ==========================================================
// Phase codes {hi, lo}
`define DSPS_PH_INTEG 2'h2
`define DSPS_PH_DEINT 2'h3
`define DSPS_PH_NULL 2'h0
`define DSPS_PH_AZ 2'h1

`endif

// file: hdl/dsps_pkg.sv
// Types shared by the dual-slope phase sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package dsps_pkg;

   // ==========================================================
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_PREZERO = 3'b001,
      ST_INTEG   = 3'b010,
      ST_DEINT   = 3'b011,
      ST_NULL    = 3'b100
   } dsps_state_t;

endpackage

// file: hdl/dsps_tick_div.sv
// Count-period divider: one-cycle enable every DIV clocks.
// Assumes i_restart realigns the period to the current cycle.
`timescale 1ns/1ps
module dsps_tick_div #(
   parameter int DIV = 125,
   parameter int W = 16
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Control
   input wire logic i_restart,
   // Enable out
   output logic o_tick
);
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   localparam logic [W-1:0] ONE = W'(1);

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;

   always_comb begin
      if (i_restart || cnt == LAST) begin
         next_cnt = '0;
      end else begin
         next_cnt = cnt + ONE;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   // Tick ignores i_restart: the caller derives i_restart from logic that reads the tick
   assign o_tick = (cnt == LAST);
endmodule

// file: hdl/dsps_cmp_watch.sv
// Comparator watcher: registered level plus edge pulses.
// Assumes the comparator input is synchronous to i_clk.
`timescale 1ns/1ps
module dsps_cmp_watch (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Comparator
   input wire logic i_level,
   // Observed level and edges
   output logic o_level,
   output logic o_fall,
   output logic o_rise
);
   logic next_level;

   always_comb begin
      next_level = i_level;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_level <= 1'b0;
      end else begin
         o_level <= next_level;
      end
   end

   // Edges use the live input so the phase can switch at once
   assign o_fall = o_level && !i_level;
   assign o_rise = !o_level && i_level;
endmodule

// file: hdl/dsps_sequencer.sv
// Host-side controller that steps a dual-slope converter front end through its phases.
// Assumes the comparator output is synchronous to i_clk and phase pins reach the device directly.
// What this block does
// - Hold auto-zero before integrating for AZ_COUNTS counts, whose default matches the integrate phase only at the default line settings.
// - Auto-zero is the idle state and may last without limit.
// - Integrate duration is identical for every conversion.
// - Sample comparator in the last cycle of integrate, just before switching to 11.
// - The comparator level sampled then becomes the sign of the result.
// - De-integrate is timed from the 10 to 11 change to the comparator fall.
// - Budget for the typical 2 us comparator lag as two whole 1 us counts.
// - End de-integrate promptly after the comparator falls, minimising overshoot.
// - Provide both the comparator level and a capture pulse.
// - After a de-integrate that ends on a comparator fall, drive 00 and hold until the comparator returns high.
// - Leave output null immediately once the comparator goes high.
// - After output null select auto-zero 01 and hold until the next conversion.
// - Integrate duration is a whole number of mains line periods.
// - De-integrate count limit is twice the integrate count.
`timescale 1ns/1ps
`include "dsps_defines.svh"
module dsps_sequencer #(
   parameter int CNT_W = 18,
   parameter int TICK_CYCLES = `DSPS_TICK_CYCLES,
   parameter int LINE_COUNTS = `DSPS_LINE_COUNTS,
   parameter int INT_LINES = `DSPS_INT_LINES,
   parameter int AZ_COUNTS = `DSPS_INT_LINES * `DSPS_LINE_COUNTS,
   parameter int DEINT_FACTOR = `DSPS_DEINT_FACTOR,
   parameter int LAG_COUNTS = `DSPS_CMP_LAG_COUNTS,
   parameter bit LAG_COMP = 1'b0
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // User request
   input wire logic i_start,
   input wire logic [1:0] i_chan,
   // Device comparator
   input wire logic i_zero_cross,
   // Device phase and channel pins
   output logic o_phs_sel_hi,
   output logic o_phs_sel_lo,
   output logic o_chn_sel_hi,
   output logic o_chn_sel_lo,
   // Result
   output logic o_busy,
   output logic o_done,
   output logic o_timeout,
   output logic o_sign,
   output logic [CNT_W-1:0] o_magnitude,
   // Comparator observation
   output logic o_cmp_level,
   output logic o_capture
);
   // ==========================================================
   // Derived counts
   localparam int INT_COUNTS = INT_LINES * LINE_COUNTS;
   localparam int DEINT_MAX = DEINT_FACTOR * INT_COUNTS;
   localparam logic [CNT_W-1:0] INT_LAST = CNT_W'(INT_COUNTS - 1);
   localparam logic [CNT_W-1:0] AZ_LAST = CNT_W'(AZ_COUNTS - 1);
   localparam logic [CNT_W-1:0] DEINT_LAST = CNT_W'(DEINT_MAX - 1);
   localparam logic [CNT_W-1:0] LAG_CNT = CNT_W'(LAG_COUNTS);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   dsps_pkg::dsps_state_t state;
   dsps_pkg::dsps_state_t next_state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [1:0] phase;
   logic [1:0] next_phase;
   logic [1:0] chan;
   logic [1:0] next_chan;
   logic next_done;
   logic next_timeout;
   logic next_sign;
   logic [CNT_W-1:0] next_magnitude;
   logic next_capture;
   logic tick;
   logic cmp_fall;
   logic cmp_rise;
   logic restart;

   // ==========================================================
   // Helpers
   function automatic logic [1:0] phase_of(input dsps_pkg::dsps_state_t s);
      case (s)
         dsps_pkg::ST_INTEG: phase_of = `DSPS_PH_INTEG;
         dsps_pkg::ST_DEINT: phase_of = `DSPS_PH_DEINT;
         dsps_pkg::ST_NULL: phase_of = `DSPS_PH_NULL;
         default: phase_of = `DSPS_PH_AZ;
      endcase
   endfunction

   // Lag correction is optional: the lag is typical, not guaranteed
   function automatic logic [CNT_W-1:0] lag_adjust(input logic [CNT_W-1:0] c);
      if (!LAG_COMP) begin
         lag_adjust = c;
      end else if (c >= LAG_CNT) begin
         lag_adjust = c - LAG_CNT;
      end else begin
         lag_adjust = '0;
      end
   endfunction

   // ==========================================================
   // Count divider and comparator watcher
   assign restart = (next_state != state);

   dsps_tick_div #(
      .DIV(TICK_CYCLES),
      .W(16)
   ) u_tick (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_restart(restart),
      .o_tick(tick)
   );

   dsps_cmp_watch u_cmp (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_level(i_zero_cross),
      .o_level(o_cmp_level),
      .o_fall(cmp_fall),
      .o_rise(cmp_rise)
   );

   // ==========================================================
   // Sequencer
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_chan = chan;
      next_done = 1'b0;
      next_timeout = 1'b0;
      next_sign = o_sign;
      next_magnitude = o_magnitude;
      next_capture = 1'b0;
      if (tick) begin
         next_cnt = cnt + CNT_ONE;
      end
      case (state)
         dsps_pkg::ST_IDLE: begin
            // Idle sits in auto-zero for as long as needed
            if (i_start) begin
               next_chan = i_chan;
               next_state = dsps_pkg::ST_PREZERO;
            end
         end
         dsps_pkg::ST_PREZERO: begin
            if (tick && cnt == AZ_LAST) begin
               next_state = dsps_pkg::ST_INTEG;
            end
         end
         dsps_pkg::ST_INTEG: begin
            // Early readings are noisy near zero input, so only the last cycle counts
            if (tick && cnt == INT_LAST) begin
               next_sign = i_zero_cross;
               next_state = dsps_pkg::ST_DEINT;
            end
         end
         dsps_pkg::ST_DEINT: begin
            if (cmp_fall) begin
               next_capture = 1'b1;
               next_magnitude = lag_adjust(cnt);
               next_done = 1'b1;
               next_state = dsps_pkg::ST_NULL;
            end else if (tick && cnt == DEINT_LAST) begin
               next_timeout = 1'b1;
               next_magnitude = '0;
               next_state = dsps_pkg::ST_IDLE;
            end
         end
         dsps_pkg::ST_NULL: begin
            if (i_zero_cross) begin
               next_state = dsps_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = dsps_pkg::ST_IDLE;
         end
      endcase
      if (next_state != state) begin
         next_cnt = '0;
      end
      // Pins follow the state on the same edge; the device does not latch them
      next_phase = phase_of(next_state);
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= dsps_pkg::ST_IDLE;
         cnt <= '0;
         phase <= `DSPS_PH_AZ;
         chan <= 2'h0;
         o_done <= 1'b0;
         o_timeout <= 1'b0;
         o_sign <= 1'b0;
         o_magnitude <= '0;
         o_capture <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         phase <= next_phase;
         chan <= next_chan;
         o_done <= next_done;
         o_timeout <= next_timeout;
         o_sign <= next_sign;
         o_magnitude <= next_magnitude;
         o_capture <= next_capture;
      end
   end

   assign o_phs_sel_hi = phase[1];
   assign o_phs_sel_lo = phase[0];
   assign o_chn_sel_hi = chan[1];
   assign o_chn_sel_lo = chan[0];
   assign o_busy = (state != dsps_pkg::ST_IDLE);

   // ==========================================================
   // Checks
   // Tick counters for the phase-length checks
   logic [CNT_W:0] hlp_int_ticks;
   logic [CNT_W:0] hlp_az_ticks;

   always_ff @(posedge i_clk) begin
      if (i_rst || state != dsps_pkg::ST_INTEG) begin
         hlp_int_ticks <= '0;
      end else if (tick) begin
         hlp_int_ticks <= hlp_int_ticks + (CNT_W+1)'(1);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || state != dsps_pkg::ST_PREZERO) begin
         hlp_az_ticks <= '0;
      end else if (tick) begin
         hlp_az_ticks <= hlp_az_ticks + (CNT_W+1)'(1);
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   AST_PHASE_MATCH: assert property (phase == phase_of(state))
      else $error("phase pins disagree with state");

   AST_IDLE_AZ: assert property ((state == dsps_pkg::ST_IDLE) |-> (phase == `DSPS_PH_AZ && !o_busy))
      else $error("idle not in auto-zero");

   AST_AZ_LEN: assert property ((state == dsps_pkg::ST_PREZERO && next_state == dsps_pkg::ST_INTEG)
      |-> (tick && hlp_az_ticks == (CNT_W+1)'(AZ_COUNTS - 1)))
      else $error("auto-zero length wrong");

   AST_INT_LEN: assert property ((state == dsps_pkg::ST_INTEG && next_state == dsps_pkg::ST_DEINT)
      |-> (tick && hlp_int_ticks == (CNT_W+1)'(INT_COUNTS - 1)))
      else $error("integrate length wrong");

   AST_SIGN_SAMPLE: assert property ((state == dsps_pkg::ST_INTEG && next_state == dsps_pkg::ST_DEINT)
      |=> (o_sign == $past(i_zero_cross) && phase == `DSPS_PH_DEINT))
      else $error("sign not taken at end of integrate");

   // A short reset can cut integrate; the edge after it is not a phase step
   AST_INT_TO_DEINT: assert property ((!$past(i_rst) && $past(phase) == `DSPS_PH_INTEG)
      |-> (phase == `DSPS_PH_INTEG || phase == `DSPS_PH_DEINT))
      else $error("integrate not followed by de-integrate");

   AST_PROMPT_END: assert property ((state == dsps_pkg::ST_DEINT && cmp_fall)
      |=> (phase == `DSPS_PH_NULL && o_capture && o_done))
      else $error("de-integrate not ended on comparator fall");

   AST_NULL_HOLD: assert property ((state == dsps_pkg::ST_NULL && !i_zero_cross)
      |=> (phase == `DSPS_PH_NULL))
      else $error("output null left early");

   AST_NULL_EXIT: assert property ((state == dsps_pkg::ST_NULL && i_zero_cross)
      |=> (phase == `DSPS_PH_AZ && !o_busy))
      else $error("output null not left at once");

   AST_TIMEOUT: assert property ((state == dsps_pkg::ST_DEINT && !cmp_fall && tick && cnt == DEINT_LAST)
      |=> (o_timeout && !o_done && phase == `DSPS_PH_AZ))
      else $error("de-integrate timeout not taken");

   AST_MAG_RANGE: assert property ($rose(o_done) |-> (o_magnitude <= DEINT_LAST && !o_timeout))
      else $error("magnitude beyond limit");

   AST_CAPTURE_PAIR: assert property (o_capture == o_done)
      else $error("capture pulse apart from done");

   // Level output is one clock late; the edge right after reset has no history
   AST_LEVEL_DELAY: assert property (!$past(i_rst) |-> (o_cmp_level == $past(i_zero_cross)))
      else $error("comparator level not one clock behind");

   AST_TIMEOUT_NO_NULL: assert property (o_timeout
      |-> (state == dsps_pkg::ST_IDLE && phase == `DSPS_PH_AZ))
      else $error("timeout did not return to auto-zero");

   // Main scenarios
   COV_POS: cover property (o_done && o_sign);
   COV_NEG: cover property (o_done && !o_sign);
   COV_TIMEOUT: cover property (o_timeout);
   COV_NULL_WAIT: cover property ((state == dsps_pkg::ST_NULL && !i_zero_cross)
      ##1 (state == dsps_pkg::ST_NULL && i_zero_cross) ##1 (state == dsps_pkg::ST_IDLE));
   COV_REFUSED_START: cover property (o_busy && i_start);
endmodule

// file: dv/dsps_dev_model.sv
// Behavioural model of the converter front end behind the phase, channel and comparator pins.
// Assumes pins change just after i_clk edges and the comparator must look synchronous to i_clk.
`timescale 1ns/1ps
module dsps_dev_model #(
   parameter int REF_STEP = 3,
   parameter int PUMP_DIV = 625
) (
   // Clock
   input wire logic i_clk,
   // Phase and channel pins
   input wire logic i_phs_sel_hi,
   input wire logic i_phs_sel_lo,
   input wire logic i_chn_sel_hi,
   input wire logic i_chn_sel_lo,
   // Bench controls: one signed byte per channel, null residue length
   input wire logic [31:0] i_vin,
   input wire logic [2:0] i_null_wait,
   // Comparator
   output logic o_zero_cross
);
   // ==========================================================
   // Pin decode and integrator
   logic [1:0] phase;
   logic [1:0] chan;
   logic az_noise = 1'b0;
   logic pump_ph = 1'b0;
   int acc = 0;
   int rem = 0;
   int nxt;
   int null_cnt = 0;
   int pump_cnt = 0;
   assign phase = {i_phs_sel_hi, i_phs_sel_lo};
   assign chan = {i_chn_sel_hi, i_chn_sel_lo};
   always @(posedge i_clk) begin
      az_noise <= ~az_noise;
      case (phase)
         2'h2: begin
            nxt = acc + $signed(i_vin[{chan, 3'b000} +: 8]);
            acc <= nxt;
            rem <= (nxt < 0) ? -nxt : nxt;
         end
         2'h3: rem <= rem - REF_STEP;
         2'h0: begin
            acc <= 0;
            null_cnt <= null_cnt + 1;
         end
         default: begin
            acc <= 0;
            null_cnt <= 0;
         end
      endcase
   end
   // ==========================================================
   // Comparator; undefined in auto-zero, so it toggles there
   always_comb begin
      case (phase)
         2'h2: o_zero_cross = (acc > 0);
         2'h3: o_zero_cross = (rem > 0);
         2'h0: o_zero_cross = (null_cnt >= int'(i_null_wait));
         default: o_zero_cross = az_noise;
      endcase
   end
   // ==========================================================
   // Charge pump: two phases of PUMP_DIV clocks each, 100 kHz at 125 MHz
   always @(posedge i_clk) begin
      if (pump_cnt == PUMP_DIV - 1) begin
         pump_cnt <= 0;
         pump_ph <= ~pump_ph;
      end else begin
         pump_cnt <= pump_cnt + 1;
      end
   end
endmodule

// file: dv/testbench.sv
// Self-checking bench for the phase sequencer against the front end model.
// Assumes short counts: one clock per count, three-count integrate and auto-zero.
`timescale 1ns/1ps
module testbench;
   // ==========================================================
   // Signals
   localparam int INT_LEN = 3;
   localparam int DEINT_MAX = 2 * INT_LEN;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_start = 1'b0;
   logic [1:0] i_chan = 2'h0;
   logic [31:0] vin = 32'h0000_0000;
   logic [2:0] null_wait = 3'h0;
   logic zc, phs_hi, phs_lo, chn_hi, chn_lo, busy, done, tmo, sign, cmp_level, capture;
   logic [17:0] magnitude;
   logic [17:0] magnitude_lag;
   localparam int LAG = 2;
   int failures = 0;
   int checked = 0;
   int n_ph[4];
   logic up = 1'b0;
   logic last_zc = 1'b0;
   always #4 i_clk = ~i_clk;

   dsps_sequencer #(.TICK_CYCLES(1), .LINE_COUNTS(3), .INT_LINES(1), .AZ_COUNTS(3)) dut_u (
      .i_clk(i_clk), .i_rst(i_rst), .i_start(i_start), .i_chan(i_chan), .i_zero_cross(zc),
      .o_phs_sel_hi(phs_hi), .o_phs_sel_lo(phs_lo), .o_chn_sel_hi(chn_hi), .o_chn_sel_lo(chn_lo),
      .o_busy(busy), .o_done(done), .o_timeout(tmo), .o_sign(sign), .o_magnitude(magnitude),
      .o_cmp_level(cmp_level), .o_capture(capture));

   dsps_dev_model dev_u (
      .i_clk(i_clk), .i_phs_sel_hi(phs_hi), .i_phs_sel_lo(phs_lo), .i_chn_sel_hi(chn_hi),
      .i_chn_sel_lo(chn_lo), .i_vin(vin), .i_null_wait(null_wait), .o_zero_cross(zc));

   // Lag correction on; phases track dut_u exactly, so it can share the model's comparator
   dsps_sequencer #(.TICK_CYCLES(1), .LINE_COUNTS(3), .INT_LINES(1), .AZ_COUNTS(3), .LAG_COMP(1'b1)) dut_lag_u (
      .i_clk(i_clk), .i_rst(i_rst), .i_start(i_start), .i_chan(i_chan), .i_zero_cross(zc),
      .o_phs_sel_hi(), .o_phs_sel_lo(), .o_chn_sel_hi(), .o_chn_sel_lo(), .o_busy(), .o_done(),
      .o_timeout(), .o_sign(), .o_magnitude(magnitude_lag), .o_cmp_level(), .o_capture());

   // ==========================================================
   // Checking and closing
   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("counts checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Phase lengths per conversion, cleared while idle
   always @(posedge i_clk) begin
      if (up) begin
         check("cmp_level", 18'(cmp_level), 18'(last_zc));
         check("capture", 18'(capture), 18'(done));
      end
      up = !i_rst;
      last_zc = zc;
      if (busy !== 1'b1) begin
         n_ph = '{0, 0, 0, 0};
      end else begin
         n_ph[{phs_hi, phs_lo}]++;
      end
   end

   // ==========================================================
   // One conversion, with a refused start while busy
   task automatic conv(input logic [1:0] ch, input logic [31:0] vals, input logic [2:0] nw);
      int v;
      int d;
      int n;
      logic to;
      v = $signed(vals[{ch, 3'b000} +: 8]);
      d = (v < 0) ? -v : v;
      to = (d == 0) || (d >= DEINT_MAX);
      @(posedge i_clk);
      vin <= vals;
      null_wait <= nw;
      i_start <= 1'b1;
      i_chan <= ch;
      @(posedge i_clk);
      i_start <= 1'b0;
      i_chan <= ~ch;
      @(posedge i_clk);
      i_start <= 1'b1;
      @(posedge i_clk);
      i_start <= 1'b0;
      n = 0;
      do begin
         @(posedge i_clk);
         #1;
         n++;
      end while (done !== 1'b1 && tmo !== 1'b1 && n < 100);
      check("conv_wait", 18'(n < 100), 18'h1);
      check("done", 18'(done), 18'(!to));
      check("capture_pulse", 18'(capture), 18'(!to));
      check("timeout", 18'(tmo), 18'(to));
      check("sign", 18'(sign), 18'(v > 0));
      check("magnitude", magnitude, to ? 18'h0 : 18'(d));
      check("magnitude_lag", magnitude_lag, to ? 18'h0 : 18'((d > LAG) ? d - LAG : 0));
      check("phase_end", 18'({phs_hi, phs_lo}), to ? 18'h1 : 18'h0);
      n = 0;
      while (busy !== 1'b0 && n < 50) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      check("idle_wait", 18'(n < 50), 18'h1);
      check("phase_idle", 18'({phs_hi, phs_lo}), 18'h1);
      check("chan_pins", 18'({chn_hi, chn_lo}), 18'(ch));
      check("az_len", 18'(n_ph[1]), 18'(INT_LEN));
      check("int_len", 18'(n_ph[2]), 18'(INT_LEN));
      if (!to) check("deint_len", 18'(n_ph[3]), 18'(d + 1));
      check("null_len", 18'(n_ph[0]), to ? 18'h0 : 18'(nw + 1));
      $display("test done ch %0d input %0d", ch, v);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      int unsigned s;
      logic [31:0] r;
      s = $urandom(20956);
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      // Corners: largest counts, zero-length and longest null, no fall, too long
      conv(2'h1, 32'h0000_0500, 3'h0);
      conv(2'h2, 32'h00FB_0000, 3'h7);
      conv(2'h3, 32'h0000_0000, 3'h2);
      conv(2'h0, 32'h0303_0307, 3'h1);
      conv(2'h0, 32'h0303_03FF, 3'h3);
      repeat (30) begin
         for (int k = 0; k < 4; k++) begin
            r[k*8 +: 8] = 8'($urandom_range(10, 0)) - 8'h05;
         end
         conv(2'($urandom_range(3, 0)), r, 3'($urandom_range(7, 0)));
      end
      complete_run();
   end

   // Hang guard, far beyond the few hundred cycles needed
   initial begin
      #(8 * 20000);
      failures++;
      $display("BAD watchdog expected finish seen hang");
      complete_run();
   end
endmodule
